/* File: rtl/dac_params.svh */
// Register indices, field positions, reset values and timing counts of the converter control
`ifndef DAC_PARAMS_SVH
`define DAC_PARAMS_SVH

`define ADDR_W 8
`define DATA_W 12

`define IDX_CTRL_A 6'h00
`define IDX_CTRL_B 6'h01
`define IDX_CTRL_C 6'h02
`define IDX_EV_CTRL 6'h03
`define IDX_STATUS 6'h05
`define IDX_OFFSET_TRIM 6'h08
`define IDX_GAIN_TRIM 6'h09
`define IDX_IRQ_STATUS 6'h0c
`define IDX_IRQ_MASK 6'h0d
`define IDX_CH0_DATA 6'h18
`define IDX_DATA_STEP 6'h02

`define CTRL_A_ENABLE 0
`define CTRL_A_LOW_POWER 1
`define CTRL_A_CH0_PIN 2
`define CTRL_A_CH1_PIN 3
`define CTRL_A_INT_ROUTE 4
`define CTRL_A_MASK 8'h1f
`define CTRL_B_CFG_LO 5
`define CTRL_B_MASK 8'h63
`define CTRL_C_LEFT 0
`define CTRL_C_REF_LO 3
`define CTRL_C_MASK 8'h19
`define EV_CTRL_CH1_NEXT 3
`define EV_CTRL_MASK 8'h0f
`define REG_RESET 8'h00

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`define CLK_PERIOD_NS 10
`define CONV_TIME_NS 1000
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: rtl/dac_pkg.sv */
// Types shared by the converter control and its channel module
package dac_pkg;

  typedef enum logic [1:0] {CFG_SINGLE0, CFG_SINGLE1, CFG_DUAL, CFG_RESERVED} chan_config_t;

  typedef enum logic {CONV_IDLE, CONV_RUN} conv_state_t;

  typedef struct packed {
    logic active;
    logic event_mode;
    logic low_power;
    logic [7:0] offset;
    logic [7:0] gain;
  } chan_ctl_t;

  typedef struct packed {
    logic empty;
    logic busy;
    logic done;
  } chan_stat_t;

endpackage

/* File: rtl/dac_channel.sv */
// One converter channel: pending sample, trigger logic, conversion timer and trimmed output code
`include "dac_params.svh"

module dac_channel
  import dac_pkg::*;
#(
  parameter int CONV_CYCLES = `CONV_CYCLES
)
(
  input wire logic clk,
  input wire logic reset_n,
  input chan_ctl_t ctl,
  input wire logic write_strobe,
  input wire logic [`DATA_W-1:0] write_value,
  input wire logic event_pulse,
  output chan_stat_t stat,
  output logic [`DATA_W-1:0] code,
  output logic [`DATA_W-1:0] data_value
);

  localparam int CW = $clog2(2 * CONV_CYCLES + 1);

  conv_state_t state;
  logic [CW-1:0] count;
  logic [`DATA_W-1:0] conv_data;
  logic updated;
  logic empty;
  logic done;
  logic start;
  logic auto_start;

  function automatic logic [`DATA_W-1:0] trim(input logic [`DATA_W-1:0] d,
                                               input logic [7:0] off,
                                               input logic [7:0] gn);
    logic signed [23:0] centred;
    logic signed [23:0] prod;
    logic signed [15:0] gterm;
    logic signed [15:0] oterm;
    logic signed [15:0] sum;
    centred = $signed({12'h000, d}) - 24'sd2048;
    prod = centred * $signed({17'h00000, gn[6:0]});
    gterm = {{2{prod[23]}}, prod[23:10]};
    if (gn[7])
    begin
      gterm = -gterm;
    end
    oterm = $signed({9'h000, off[6:0]});
    if (!off[7])
    begin
      oterm = -oterm;
    end
    sum = $signed({4'h0, d}) + gterm + oterm;
    if (sum < 16'sd0)
    begin
      trim = 12'h000;
    end
    else if (sum > 16'sd4095)
    begin
      trim = 12'hfff;
    end
    else
    begin
      trim = sum[11:0];
    end
  endfunction

  // Auto mode converts the word being written; event mode converts what is pending
  assign auto_start = ctl.active & ~ctl.event_mode & write_strobe;
  assign start = auto_start | (ctl.active & ctl.event_mode & event_pulse & updated);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      data_value <= 12'h000;
    end
    else if (write_strobe)
    begin
      data_value <= write_value;
    end
  end

  // A write landing with an event-mode start re-arms the flag for the new word
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      updated <= 1'b0;
      empty <= 1'b0;
    end
    else
    begin
      if (write_strobe && !auto_start)
      begin
        updated <= 1'b1;
        empty <= 1'b0;
      end
      else if (start)
      begin
        updated <= 1'b0;
        empty <= 1'b1;
      end
    end
  end

  // A new start restarts a running conversion rather than queueing behind it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= CONV_IDLE;
      count <= '0;
      conv_data <= 12'h000;
      code <= 12'h000;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        CONV_IDLE:
        begin
          if (start)
          begin
            state <= CONV_RUN;
          end
        end
        CONV_RUN:
        begin
          if (!start && count == '0)
          begin
            state <= CONV_IDLE;
            code <= trim(conv_data, ctl.offset, ctl.gain);
            done <= 1'b1;
          end
          else if (!start)
          begin
            count <= count - 1'b1;
          end
        end
        default:
        begin
          state <= CONV_IDLE;
        end
      endcase
      if (start)
      begin
        conv_data <= auto_start ? write_value : data_value;
        count <= ctl.low_power ? CW'(2 * CONV_CYCLES - 1) : CW'(CONV_CYCLES - 1);
      end
    end
  end

  assign stat.empty = empty;
  assign stat.busy = (state == CONV_RUN);
  assign stat.done = done;

  a_lp_double: assert property (@(posedge clk) disable iff (!reset_n)
    (start && ctl.low_power) |=> (stat.busy && count == CW'(2 * CONV_CYCLES - 1)))
    else $error("low power conversion not loaded with doubled time");

  a_normal_time: assert property (@(posedge clk) disable iff (!reset_n)
    (start && !ctl.low_power) |=> (stat.busy && count == CW'(CONV_CYCLES - 1)))
    else $error("normal conversion not loaded with its time");

  a_auto_start: assert property (@(posedge clk) disable iff (!reset_n)
    (write_strobe && ctl.active && !ctl.event_mode) |=> (stat.busy && conv_data == $past(write_value)))
    else $error("write did not start conversion of the written value");

  a_event_update: assert property (@(posedge clk) disable iff (!reset_n)
    (ctl.event_mode && event_pulse && !updated && !write_strobe) |=> ($stable(conv_data) && !$rose(stat.busy)))
    else $error("event started a conversion without new data");

  a_done_code: assert property (@(posedge clk) disable iff (!reset_n)
    (stat.busy && count == '0 && !start) |=> (done && code == trim($past(conv_data), $past(ctl.offset), $past(ctl.gain))))
    else $error("finished conversion did not present the trimmed code");

  a_idle_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    (!ctl.active && !stat.busy) |=> !stat.busy)
    else $error("inactive channel started a conversion");

  a_empty_clear: assert property (@(posedge clk) disable iff (!reset_n)
    (write_strobe && ctl.event_mode) |=> !stat.empty)
    else $error("empty flag still set after a pending write");

endmodule

/* File: rtl/dac_ctrl.sv */
// Two-channel 12-bit converter control with an AXI4-Lite register slave
`include "dac_params.svh"

// Function
// - A data write starts that channel's conversion by default.
// - In event mode, an event starts conversion only if data changed since last conversion.
// - Two channels, each taking a 12-bit sample.
// - Channels have separate data, conversion control and output.
// - Low-power mode doubles each conversion's duration.
// - Logic and data registers run on the single peripheral clock.
// - Internal-route bit 4 sends channel 0 inside and turns off its pin.
// - Channel 1 pin-enable bit 3 puts channel 1 on its pin.
// - Signed 8-bit offset and gain trims correct the converted code.
// - Two-bit config picks channel 0, channel 1 or both; 11 reserved.
// - Per-channel event-trigger bits 1 and 0 enable event-started conversions.
// - Data-empty flags show room for data and drive the DMA requests.
// - Sample words are right-justified by default, left-justified on request.
module dac_ctrl
  import dac_pkg::*;
#(
  parameter int CONV_CYCLES = `CONV_CYCLES,
  parameter int EVENT_LINES = 8
)
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [`ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [`ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic [EVENT_LINES-1:0] EVENT_IN,
  output logic [`DATA_W-1:0] CH0_CODE,
  output logic [`DATA_W-1:0] CH1_CODE,
  output logic CH0_PIN_EN,
  output logic CH1_PIN_EN,
  output logic CH0_INTERNAL_EN,
  output logic LOW_POWER,
  output logic [1:0] REF_SELECT,
  output logic [1:0] DMA_REQ,
  output logic IRQ
);

  if (CONV_CYCLES < 1 || CONV_CYCLES > 16383)
  begin : g_bad_conv
    $error("CONV_CYCLES out of range");
  end
  if (EVENT_LINES != 8)
  begin : g_bad_events
    $error("EVENT_LINES must be 8 for the 3-bit selector");
  end

  logic [7:0] converter_control_a;
  logic [7:0] converter_control_b;
  logic [7:0] converter_control_c;
  logic [7:0] event_control;
  logic [7:0] offset_trim;
  logic [7:0] gain_trim;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;

  logic aw_held;
  logic w_held;
  logic [5:0] aw_index;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] next_rdata;
  logic [5:0] ar_index;

  logic enable;
  logic left_justify;
  chan_config_t channel_config;
  logic [2:0] ev_sel0;
  logic [2:0] ev_sel1;

  chan_stat_t stat [2];
  logic [`DATA_W-1:0] code [2];
  logic [`DATA_W-1:0] data_value [2];
  logic [1:0] chan_active;
  logic [1:0] event_trigger;
  logic [1:0] done_evt;

  assign enable = converter_control_a[`CTRL_A_ENABLE];
  assign left_justify = converter_control_c[`CTRL_C_LEFT];
  assign channel_config = chan_config_t'(converter_control_b[`CTRL_B_CFG_LO +: 2]);
  assign event_trigger = converter_control_b[1:0];
  assign ev_sel0 = event_control[2:0];
  assign ev_sel1 = event_control[2:0] + {2'b00, event_control[`EV_CTRL_CH1_NEXT]};

  // Reserved config value leaves both channels idle rather than guessing a mode
  assign chan_active[0] = enable & (channel_config == CFG_SINGLE0 || channel_config == CFG_DUAL);
  assign chan_active[1] = enable & (channel_config == CFG_SINGLE1 || channel_config == CFG_DUAL);

  // Write channel: address and data may arrive in either order
  assign AWREADY = ~aw_held;
  assign WREADY = ~w_held;
  assign do_write = aw_held & w_held & ~BVALID;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_index <= 6'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        aw_held <= 1'b1;
        aw_index <= AWADDR[`ADDR_W-1:2];
      end
      else if (do_write)
      begin
        aw_held <= 1'b0;
      end
      if (WVALID && WREADY)
      begin
        w_held <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      else if (do_write)
      begin
        w_held <= 1'b0;
      end
    end
  end

  always_comb
  begin
    wr_hit = 1'b0;
    case (aw_index)
      `IDX_CTRL_A, `IDX_CTRL_B, `IDX_CTRL_C, `IDX_EV_CTRL, `IDX_STATUS, `IDX_OFFSET_TRIM,
      `IDX_GAIN_TRIM, `IDX_IRQ_STATUS, `IDX_IRQ_MASK, `IDX_CH0_DATA,
      `IDX_CH0_DATA + `IDX_DATA_STEP:
      begin
        wr_hit = 1'b1;
      end
      default:
      begin
        wr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      BVALID <= 1'b0;
      BRESP <= `RESP_OKAY;
    end
    else if (do_write)
    begin
      BVALID <= 1'b1;
      BRESP <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (BREADY)
    begin
      BVALID <= 1'b0;
    end
  end

  // Byte-wide control registers live in lane 0
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      converter_control_a <= `REG_RESET;
      converter_control_b <= `REG_RESET;
      converter_control_c <= `REG_RESET;
      event_control <= `REG_RESET;
      offset_trim <= `REG_RESET;
      gain_trim <= `REG_RESET;
      irq_mask <= 2'b00;
    end
    else if (do_write && w_strb[0])
    begin
      case (aw_index)
        `IDX_CTRL_A: converter_control_a <= w_data[7:0] & `CTRL_A_MASK;
        `IDX_CTRL_B: converter_control_b <= w_data[7:0] & `CTRL_B_MASK;
        `IDX_CTRL_C: converter_control_c <= w_data[7:0] & `CTRL_C_MASK;
        `IDX_EV_CTRL: event_control <= w_data[7:0] & `EV_CTRL_MASK;
        `IDX_OFFSET_TRIM: offset_trim <= w_data[7:0];
        `IDX_GAIN_TRIM: gain_trim <= w_data[7:0];
        `IDX_IRQ_MASK: irq_mask <= w_data[1:0];
        default:
        begin
        end
      endcase
    end
  end

  // A completion in the clearing cycle survives the write-one-to-clear
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      irq_status <= 2'b00;
    end
    else if (do_write && w_strb[0] && aw_index == `IDX_IRQ_STATUS)
    begin
      irq_status <= (irq_status & ~w_data[1:0]) | done_evt;
    end
    else
    begin
      irq_status <= irq_status | done_evt;
    end
  end

  for (genvar g = 0; g < 2; g++)
  begin : g_chan
    logic wr_sel;
    logic [15:0] raw;
    logic [15:0] merged;
    logic [`DATA_W-1:0] value;
    chan_ctl_t ctl;

    assign wr_sel = do_write && |w_strb[1:0] &&
                    aw_index == `IDX_CH0_DATA + 6'(g) * `IDX_DATA_STEP;
    // Untouched byte keeps its stored half so 8-bit left-justified writes need one lane
    assign raw = left_justify ? {data_value[g], 4'h0} : {4'h0, data_value[g]};
    assign merged = {w_strb[1] ? w_data[15:8] : raw[15:8], w_strb[0] ? w_data[7:0] : raw[7:0]};
    assign value = left_justify ? merged[15:4] : merged[11:0];
    assign ctl.active = chan_active[g];
    assign ctl.event_mode = event_trigger[g];
    assign ctl.low_power = converter_control_a[`CTRL_A_LOW_POWER];
    assign ctl.offset = offset_trim;
    assign ctl.gain = gain_trim;
    assign done_evt[g] = stat[g].done;
    assign DMA_REQ[g] = stat[g].empty;

    dac_channel #(
      .CONV_CYCLES(CONV_CYCLES)
    ) u_chan (
      .clk(CLK),
      .reset_n(RESET_N),
      .ctl(ctl),
      .write_strobe(wr_sel),
      .write_value(value),
      .event_pulse(EVENT_IN[g == 0 ? ev_sel0 : ev_sel1]),
      .stat(stat[g]),
      .code(code[g]),
      .data_value(data_value[g])
    );
  end

  // Read channel: one outstanding read, data registered
  assign ARREADY = ~RVALID;
  assign ar_index = ARADDR[`ADDR_W-1:2];

  always_comb
  begin
    next_rdata = 32'h00000000;
    rd_hit = 1'b1;
    case (ar_index)
      `IDX_CTRL_A: next_rdata[7:0] = converter_control_a;
      `IDX_CTRL_B: next_rdata[7:0] = converter_control_b;
      `IDX_CTRL_C: next_rdata[7:0] = converter_control_c;
      `IDX_EV_CTRL: next_rdata[7:0] = event_control;
      `IDX_STATUS: next_rdata[1:0] = {stat[1].empty, stat[0].empty};
      `IDX_OFFSET_TRIM: next_rdata[7:0] = offset_trim;
      `IDX_GAIN_TRIM: next_rdata[7:0] = gain_trim;
      `IDX_IRQ_STATUS: next_rdata[1:0] = irq_status;
      `IDX_IRQ_MASK: next_rdata[1:0] = irq_mask;
      `IDX_CH0_DATA:
        next_rdata[15:0] = left_justify ? {data_value[0], 4'h0} : {4'h0, data_value[0]};
      `IDX_CH0_DATA + `IDX_DATA_STEP:
        next_rdata[15:0] = left_justify ? {data_value[1], 4'h0} : {4'h0, data_value[1]};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= `RESP_OKAY;
    end
    else if (ARVALID && ARREADY)
    begin
      RVALID <= 1'b1;
      RDATA <= next_rdata;
      RRESP <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (RREADY)
    begin
      RVALID <= 1'b0;
    end
  end

  // Pin and analog-side controls are registered to keep glitches off the output stage
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      CH0_PIN_EN <= 1'b0;
      CH1_PIN_EN <= 1'b0;
      CH0_INTERNAL_EN <= 1'b0;
      LOW_POWER <= 1'b0;
      REF_SELECT <= 2'b00;
      CH0_CODE <= 12'h000;
      CH1_CODE <= 12'h000;
      IRQ <= 1'b0;
    end
    else
    begin
      CH0_PIN_EN <= enable & converter_control_a[`CTRL_A_CH0_PIN] &
                    ~converter_control_a[`CTRL_A_INT_ROUTE];
      CH1_PIN_EN <= enable & converter_control_a[`CTRL_A_CH1_PIN];
      CH0_INTERNAL_EN <= enable & converter_control_a[`CTRL_A_INT_ROUTE];
      LOW_POWER <= converter_control_a[`CTRL_A_LOW_POWER];
      REF_SELECT <= converter_control_c[`CTRL_C_REF_LO +: 2];
      CH0_CODE <= code[0];
      CH1_CODE <= code[1];
      IRQ <= |(irq_status & irq_mask);
    end
  end

  a_route_pin_off: assert property (@(posedge CLK) disable iff (!RESET_N)
    converter_control_a[`CTRL_A_INT_ROUTE] |=> (!CH0_PIN_EN && CH0_INTERNAL_EN == $past(enable)))
    else $error("channel 0 pin driven while routed internally");

  a_ch1_pin_on: assert property (@(posedge CLK) disable iff (!RESET_N)
    (enable && converter_control_a[`CTRL_A_CH1_PIN]) |=> CH1_PIN_EN)
    else $error("channel 1 pin not enabled");

  a_reserved_reads: assert property (@(posedge CLK) disable iff (!RESET_N)
    (ARVALID && ARREADY && ar_index == `IDX_CTRL_A) |=> (RVALID && RDATA[31:5] == 27'h0))
    else $error("control A reserved bits read nonzero");

  a_reserved_cfg: assert property (@(posedge CLK) disable iff (!RESET_N)
    (channel_config == CFG_RESERVED) |-> (chan_active == 2'b00))
    else $error("reserved channel config activated a channel");

  a_disabled_idle: assert property (@(posedge CLK) disable iff (!RESET_N)
    (!enable && !stat[0].busy && !stat[1].busy) |=> (!stat[0].busy && !stat[1].busy))
    else $error("conversion started while disabled");

endmodule

/* File: verif/dac_event_src.sv */
// Event system stand-in: turns one fire request into a one-cycle pulse on one event line
module dac_event_src
(
  input wire logic clk,
  input wire logic fire,
  input wire logic [2:0] line,
  output logic [7:0] events
);
  timeunit 1ns;
  timeprecision 1ps;
  // A held level would count as several events, so every request lasts one cycle
  always_ff @(posedge clk)
  begin
    events <= fire ? 8'h01 << line : 8'h00;
  end
endmodule

/* File: verif/test_dac_ctrl.sv */
// Self-checking bench for the two-channel converter control
`include "dac_params.svh"
module test_dac_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CONV = 4;
  logic CLK = 0, RESET_N = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic [7:0] AWADDR = 0, ARADDR = 0, EVENT_IN;
  logic [31:0] WDATA = 0, RDATA, rd_data;
  logic [3:0] WSTRB = 0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, CH0_PIN_EN, CH1_PIN_EN;
  logic CH0_INTERNAL_EN, LOW_POWER, fire = 0;
  logic [1:0] BRESP, RRESP, REF_SELECT, DMA_REQ, rd_resp, wr_resp;
  logic [11:0] CH0_CODE, CH1_CODE;
  logic [2:0] line = 0;
  int n_fail = 0, num_checks = 0, seed = 37995;

  always #5 CLK = ~CLK;

  dac_ctrl #(.CONV_CYCLES(CONV), .EVENT_LINES(8)) i_dac_ctrl (.CLK(CLK), .RESET_N(RESET_N),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY), .EVENT_IN(EVENT_IN), .CH0_CODE(CH0_CODE),
    .CH1_CODE(CH1_CODE), .CH0_PIN_EN(CH0_PIN_EN), .CH1_PIN_EN(CH1_PIN_EN),
    .CH0_INTERNAL_EN(CH0_INTERNAL_EN), .LOW_POWER(LOW_POWER), .REF_SELECT(REF_SELECT),
    .DMA_REQ(DMA_REQ), .IRQ(IRQ));

  dac_event_src i_dac_event_src (.clk(CLK), .fire(fire), .line(line), .events(EVENT_IN));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Ready is sampled at the falling edge, where it has settled, and acted on at the next rise
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic aw, w, ta, tw;
    aw = 0;
    w = 0;
    @(posedge CLK);
    AWADDR <= {idx, 2'b00};
    WDATA <= d;
    WSTRB <= 4'hf;
    AWVALID <= 1;
    WVALID <= 1;
    BREADY <= 1;
    while (!(aw && w))
    begin
      @(negedge CLK);
      ta = AWVALID && AWREADY;
      tw = WVALID && WREADY;
      @(posedge CLK);
      if (ta)
        AWVALID <= 0;
      if (tw)
        WVALID <= 0;
      aw = aw || ta;
      w = w || tw;
    end
    do @(negedge CLK); while (BVALID !== 1'b1);
    wr_resp = BRESP;
    @(posedge CLK);
    BREADY <= 0;
  endtask

  task automatic rd(input logic [5:0] idx);
    @(posedge CLK);
    ARADDR <= {idx, 2'b00};
    ARVALID <= 1;
    RREADY <= 1;
    do @(negedge CLK); while (ARREADY !== 1'b1);
    @(posedge CLK);
    ARVALID <= 0;
    do @(negedge CLK); while (RVALID !== 1'b1);
    rd_data = RDATA;
    rd_resp = RRESP;
    @(posedge CLK);
    RREADY <= 0;
  endtask

  task automatic pulse(input logic [2:0] l);
    @(posedge CLK);
    fire <= 1;
    line <= l;
    @(posedge CLK);
    fire <= 0;
  endtask

  task automatic conv(input int ch, input logic [11:0] exp, output int n);
    n = 0;
    while ((ch ? CH1_CODE : CH0_CODE) !== exp && n < 40)
    begin
      @(negedge CLK);
      n++;
    end
    cmp(ch ? CH1_CODE : CH0_CODE, exp);
  endtask

  task automatic idle;
    repeat (3 * CONV) @(posedge CLK);
  endtask

  // Reference trim: signed offset in LSBs, gain rotating around mid code, clamped to 12 bits
  function automatic int trim(input int d, input int off, input int g);
    int r;
    int k;
    k = (d - 2048) * (g % 128);
    // Round toward minus infinity, as an arithmetic shift would
    k = k >= 0 ? k / 1024 : -((1023 - k) / 1024);
    r = d + (off >= 128 ? off % 128 : -(off % 128)) + (g >= 128 ? -k : k);
    return r < 0 ? 0 : (r > 4095 ? 4095 : r);
  endfunction

  initial
  begin
    int v, w, o0, o1, n0, n1;
    int td[5] = '{'h800, 'h003, 'h900, 'h900, 'hffe};
    int to[5] = '{'h85, 'h05, 'h00, 'h00, 'h85};
    int tg[5] = '{'h00, 'h00, 'h40, 'hc0, 'h00};
    repeat (5) @(posedge CLK);
    RESET_N <= 1;
    rd(`IDX_CTRL_A);
    cmp(rd_data, 0);
    rd(`IDX_STATUS);
    cmp(rd_data, 0);
    rd(6'h3f);
    cmp(rd_resp, `RESP_SLVERR);
    wr(6'h3f, 32'h0);
    cmp(wr_resp, `RESP_SLVERR);
    $display("test reset done");
    wr(`IDX_CTRL_A, 32'h1d);
    cmp(wr_resp, `RESP_OKAY);
    idle();
    cmp(CH0_PIN_EN, 0);
    cmp(CH0_INTERNAL_EN, 1);
    cmp(CH1_PIN_EN, 1);
    rd(`IDX_CTRL_A);
    cmp(rd_data, 32'h1d);
    wr(`IDX_CTRL_A, 32'h05);
    idle();
    cmp(CH0_PIN_EN, 1);
    cmp(CH1_PIN_EN, 0);
    $display("test pins done");
    wr(`IDX_IRQ_MASK, 32'h3);
    for (int c = 0; c < 4; c++)
    begin
      wr(`IDX_CTRL_B, c << 5);
      v = $random(seed) & 'hfff;
      w = $random(seed) & 'hfff;
      o0 = CH0_CODE;
      o1 = CH1_CODE;
      wr(`IDX_CH0_DATA, v);
      wr(`IDX_CH0_DATA + `IDX_DATA_STEP, w);
      idle();
      cmp(CH0_CODE, (c == 0 || c == 2) ? v : o0);
      cmp(CH1_CODE, (c == 1 || c == 2) ? w : o1);
    end
    wr(`IDX_CTRL_B, 32'h40);
    wr(`IDX_CH0_DATA, CH0_CODE ^ 12'h0f0);
    idle();
    cmp(IRQ, 1);
    // Channel 1 last took a word while inactive, so that word is still pending
    cmp(DMA_REQ, 2'b01);
    wr(`IDX_IRQ_STATUS, 32'h3);
    idle();
    cmp(IRQ, 0);
    $display("test config done");
    wr(`IDX_CH0_DATA, CH0_CODE ^ 12'h0f0);
    conv(0, CH0_CODE ^ 12'h0f0, n0);
    wr(`IDX_CTRL_A, 32'h07);
    wr(`IDX_CH0_DATA, CH0_CODE ^ 12'hfff);
    conv(0, CH0_CODE ^ 12'hfff, n1);
    cmp(n1 - n0, CONV);
    cmp(LOW_POWER, 1);
    wr(`IDX_CTRL_A, 32'h05);
    $display("test low power done");
    for (int i = 0; i < 5; i++)
    begin
      wr(`IDX_OFFSET_TRIM, to[i]);
      wr(`IDX_GAIN_TRIM, tg[i]);
      wr(`IDX_CH0_DATA, td[i]);
      conv(0, trim(td[i], to[i], tg[i]), n0);
    end
    wr(`IDX_OFFSET_TRIM, 0);
    wr(`IDX_GAIN_TRIM, 0);
    $display("test trim done");
    wr(`IDX_CTRL_C, 32'h19);
    v = CH0_CODE ^ 12'h555;
    wr(`IDX_CH0_DATA, v << 4);
    conv(0, v, n0);
    rd(`IDX_CH0_DATA);
    cmp(rd_data, v << 4);
    cmp(REF_SELECT, 2'b11);
    wr(`IDX_CTRL_C, 32'h0);
    $display("test justify done");
    wr(`IDX_EV_CTRL, 32'h0b);
    wr(`IDX_CTRL_B, 32'h43);
    o0 = CH0_CODE;
    o1 = CH1_CODE;
    wr(`IDX_CH0_DATA, o0 ^ 'h3c3);
    wr(`IDX_CH0_DATA + `IDX_DATA_STEP, o1 ^ 'h3c3);
    idle();
    cmp(CH0_CODE, o0);
    cmp(DMA_REQ, 2'b00);
    pulse(5);
    idle();
    cmp(CH0_CODE, o0);
    pulse(3);
    conv(0, o0 ^ 'h3c3, n0);
    cmp(CH1_CODE, o1);
    pulse(4);
    conv(1, o1 ^ 'h3c3, n0);
    wr(`IDX_IRQ_STATUS, 32'h3);
    pulse(3);
    idle();
    rd(`IDX_IRQ_STATUS);
    cmp(rd_data, 0);
    $display("test events done");
    wr(`IDX_CTRL_B, 32'h40);
    wr(`IDX_CTRL_A, 32'h04);
    o0 = CH0_CODE;
    wr(`IDX_CH0_DATA, o0 ^ 1);
    idle();
    cmp(CH0_CODE, o0);
    cmp(CH0_PIN_EN, 0);
    $display("test disable done");
    complete_run();
  end

  initial
  begin
    #500000;
    n_fail++;
    complete_run();
  end
endmodule
